// ### rtl/tcc_pkg.sv
// package for the timer capture/compare base block
// shared widths, mode codes and reset values; no bus, plain ports
package tcc_pkg;
    localparam int          TCC_WIDTH      = 16;
    localparam int          TCC_CHANNELS   = 2;
    localparam int          TCC_TIMERS     = 3;
    localparam logic [15:0] TCC_COUNT_MAX  = 16'hffff;
    localparam logic [15:0] TCC_COUNT_ZERO = 16'h0000;
    localparam logic [15:0] TCC_COUNT_RST  = 16'h0000;
    localparam logic [15:0] TCC_CCVAL_RST  = 16'h0000;
    // channel mode field codes and prescaler count values
    localparam logic [3:0]  TCC_MODE_OFF      = 4'h0;
    localparam logic [3:0]  TCC_MODE_CMP_TRIG = 4'hb;
    localparam logic [3:0]  TCC_MODE_FALL     = 4'h4;
    localparam logic [3:0]  TCC_MODE_RISE     = 4'h5;
    localparam logic [3:0]  TCC_MODE_RISE4    = 4'h6;
    localparam logic [3:0]  TCC_MODE_RISE16   = 4'h7;
    localparam logic [3:0]  TCC_MODE_CMP_EVT  = 4'ha;
    localparam logic [3:0]  TCC_PRESCALE_RST  = 4'h0;
    localparam logic [3:0]  TCC_PRESCALE_4    = 4'h3;
    localparam logic [3:0]  TCC_PRESCALE_16   = 4'hf;
    // capture source select codes and default timer select
    localparam logic [2:0]  TCC_SRC_PIN  = 3'h0;
    localparam logic [2:0]  TCC_SRC_CMP1 = 3'h1;
    localparam logic [2:0]  TCC_SRC_CMP2 = 3'h2;
    localparam logic [2:0]  TCC_SRC_IOC  = 3'h3;
    localparam logic [1:0]  TCC_TMR_DEFAULT = 2'h0;
endpackage : tcc_pkg

// ### rtl/tcc_timer.sv
// one 16-bit up-counting time base with overflow flag
// count enable comes from outside; writes arrive synchronous to sys_clk
`timescale 1ns/1ns
module tcc_timer
    import tcc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        runEnable,
    input  wire logic        countTick,
    input  wire logic        writeLow,
    input  wire logic        writeHigh,
    input  wire logic [7:0]  writeData,
    input  wire logic        triggerClear,
    input  wire logic        flagClear,
    output logic      [15:0] count,
    output logic             overflowFlag
);
    logic [15:0] next_count;
    logic        next_overflowFlag;
    logic        wrap;

    always_comb
    begin
        next_count = count;
        wrap       = 1'b0;
        if (writeLow || writeHigh)
        begin
            // software write beats the trigger clear
            if (writeLow)
                next_count[7:0] = writeData;
            if (writeHigh)
                next_count[15:8] = writeData;
        end
        else if (triggerClear)
            next_count = TCC_COUNT_ZERO;
        else if (runEnable && countTick)
        begin
            wrap       = (count == TCC_COUNT_MAX);
            next_count = count + 16'h0001;
        end
        // set wins over software clear; trigger clear never sets it
        next_overflowFlag = wrap | (overflowFlag & ~flagClear);
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count        <= TCC_COUNT_RST;
            overflowFlag <= 1'b0;
        end
        else
        begin
            count        <= next_count;
            overflowFlag <= next_overflowFlag;
        end
    end

    wrapSetsFlag_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (runEnable && countTick && !writeLow && !writeHigh && !triggerClear && count == TCC_COUNT_MAX)
        |=> (overflowFlag && count == TCC_COUNT_ZERO))
        else $error("wrap did not set overflow flag");
    flagHolds_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (overflowFlag && !flagClear) |=> overflowFlag)
        else $error("overflow flag dropped without clear");
    writeWins_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (triggerClear && (writeLow || writeHigh))
        |=> (count[7:0] == ($past(writeLow) ? $past(writeData) : $past(count[7:0]))
            && count[15:8] == ($past(writeHigh) ? $past(writeData) : $past(count[15:8]))))
        else $error("trigger clear overrode write");
endmodule : tcc_timer

// ### rtl/tcc_capture_edge.sv
// capture source synchroniser, edge detect and prescaler for one channel
// source is asynchronous; mode field is a software level
`timescale 1ns/1ns
module tcc_capture_edge
    import tcc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       sourceIn,
    input  wire logic [3:0] modeField,
    output logic            captureEvent
);
    logic       syncFirst;
    logic       syncSecond;
    logic       syncLast;
    logic [3:0] prescale;
    logic [3:0] modeLast;
    logic [3:0] next_prescale;
    logic       rise;
    logic       fall;

    always_comb
    begin
        // the edge logic compares the second stage with syncLast; the first stage never feeds it
        rise          = syncSecond & ~syncLast;
        fall          = ~syncSecond & syncLast;
        next_prescale = prescale;
        captureEvent  = 1'b0;
        if (modeField != modeLast)
            next_prescale = TCC_PRESCALE_RST;
        else
        begin
            case (modeField)
                TCC_MODE_FALL:   captureEvent = fall;
                TCC_MODE_RISE:   captureEvent = rise;
                TCC_MODE_RISE4:
                begin
                    if (rise)
                        next_prescale = (prescale == TCC_PRESCALE_4) ? TCC_PRESCALE_RST : prescale + 4'h1;
                    captureEvent = rise && (prescale == TCC_PRESCALE_4);
                end
                TCC_MODE_RISE16:
                begin
                    if (rise)
                        next_prescale = prescale + 4'h1;
                    captureEvent = rise && (prescale == TCC_PRESCALE_16);
                end
                default:         captureEvent = 1'b0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            syncFirst  <= 1'b0;
            syncSecond <= 1'b0;
            syncLast   <= 1'b0;
            prescale   <= TCC_PRESCALE_RST;
            modeLast   <= TCC_MODE_OFF;
        end
        else
        begin
            syncFirst  <= sourceIn;
            syncSecond <= syncFirst;
            syncLast   <= syncSecond;
            prescale   <= next_prescale;
            modeLast   <= modeField;
        end
    end

    modeResetsPrescale_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (modeField != $past(modeField)) |=> (prescale == TCC_PRESCALE_RST))
        else $error("prescaler not reset on mode change");
    riseOnlyEvent_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (captureEvent && modeField == TCC_MODE_RISE) |-> (syncSecond && !syncLast))
        else $error("rise capture without rising edge");
endmodule : tcc_capture_edge

// ### rtl/tcc_top.sv
// timer capture/compare base: three time bases, two capture/compare channels
// all controls are plain ports synchronous to sys_clk; the async counter
// clock arrives as a tick already sampled in this domain
`timescale 1ns/1ns
module tcc_top
    import tcc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [2:0]  timerRun,
    input  wire logic [2:0]  freeRunSelect,
    input  wire logic [2:0]  syncTick,
    input  wire logic [2:0]  asyncTick,
    input  wire logic [2:0]  timerWriteLow,
    input  wire logic [2:0]  timerWriteHigh,
    input  wire logic [7:0]  timerWriteData,
    input  wire logic [2:0]  overflowFlagClear,
    input  wire logic [2:0]  overflowIrqEnable,
    input  wire logic        peripheralIrqEnable,
    input  wire logic        globalIrqEnable,
    input  wire logic        sleepMode,
    input  wire logic        secondaryOscillatorEnable,
    input  wire logic [3:0]  channelMode0,
    input  wire logic [3:0]  channelMode1,
    input  wire logic [1:0]  channelTimer0,
    input  wire logic [1:0]  channelTimer1,
    input  wire logic [2:0]  sourceSelect0,
    input  wire logic [2:0]  sourceSelect1,
    input  wire logic [1:0]  pinIn,
    input  wire logic [1:0]  pinIsOutput,
    input  wire logic [1:0]  portLatch,
    input  wire logic [1:0]  comparatorSync,
    input  wire logic [1:0]  changeEvent,
    input  wire logic [3:0]  logicCellOut,
    input  wire logic [1:0]  ccWriteLow,
    input  wire logic [1:0]  ccWriteHigh,
    input  wire logic [7:0]  ccWriteData,
    input  wire logic [1:0]  channelFlagClear,
    output logic      [15:0] timerCount0,
    output logic      [15:0] timerCount1,
    output logic      [15:0] timerCount2,
    output logic      [2:0]  overflowFlag,
    output logic      [15:0] ccValue0,
    output logic      [15:0] ccValue1,
    output logic      [1:0]  channelIrqFlag,
    output logic      [1:0]  compareEvent,
    output logic      [1:0]  conversionTrigger,
    output logic             interruptRequest,
    output logic             wakeRequest,
    output logic             vectorToIsr,
    output logic             secondaryOscillatorRun
);
    logic [15:0] count [TCC_TIMERS];
    logic [2:0]  countTick;
    logic [2:0]  triggerClear;
    logic [1:0]  captureEvent;
    logic [1:0]  sourceRaw;
    logic [15:0] channelBase [TCC_CHANNELS];
    logic [3:0]  modeOf [TCC_CHANNELS];
    logic [1:0]  timerOf [TCC_CHANNELS];
    logic [2:0]  selOf [TCC_CHANNELS];
    logic [15:0] ccValue [TCC_CHANNELS];
    logic [15:0] next_ccValue [TCC_CHANNELS];
    logic [1:0]  next_channelIrqFlag;
    logic [1:0]  next_compareEvent;
    logic [1:0]  next_conversionTrigger;
    logic [1:0]  matchNow;
    logic [1:0]  matchLast;
    logic [2:0]  overflowIrq;

    assign modeOf[0]  = channelMode0;
    assign modeOf[1]  = channelMode1;
    assign timerOf[0] = channelTimer0;
    assign timerOf[1] = channelTimer1;
    assign selOf[0]   = sourceSelect0;
    assign selOf[1]   = sourceSelect1;

    genvar t;
    generate
        for (t = 0; t < TCC_TIMERS; t++)
        begin : gTimer
            tcc_timer uTimer (
                .sys_clk      (sys_clk),
                .reset_n      (reset_n),
                .runEnable    (timerRun[t]),
                .countTick    (countTick[t]),
                .writeLow     (timerWriteLow[t]),
                .writeHigh    (timerWriteHigh[t]),
                .writeData    (timerWriteData),
                .triggerClear (triggerClear[t]),
                .flagClear    (overflowFlagClear[t]),
                .count        (count[t]),
                .overflowFlag (overflowFlag[t])
            );
        end
    endgenerate

    assign timerCount0 = count[0];
    assign timerCount1 = count[1];
    assign timerCount2 = count[2];

    genvar c;
    generate
        for (c = 0; c < TCC_CHANNELS; c++)
        begin : gChannel
            tcc_capture_edge uEdge (
                .sys_clk      (sys_clk),
                .reset_n      (reset_n),
                .sourceIn     (sourceRaw[c]),
                .modeField    (modeOf[c]),
                .captureEvent (captureEvent[c])
            );
        end
    endgenerate

    // in sleep only the free-running (async) source keeps the count moving
    always_comb
    begin
        for (int i = 0; i < TCC_TIMERS; i++)
        begin
            if (freeRunSelect[i])
                countTick[i] = asyncTick[i];
            else
                countTick[i] = syncTick[i] & ~sleepMode;
        end
    end

    // source mux; an output pin follows the port latch so writes can capture
    always_comb
    begin
        for (int i = 0; i < TCC_CHANNELS; i++)
        begin
            case (selOf[i])
                TCC_SRC_PIN:  sourceRaw[i] = pinIsOutput[i] ? portLatch[i] : pinIn[i];
                TCC_SRC_CMP1: sourceRaw[i] = comparatorSync[0];
                TCC_SRC_CMP2: sourceRaw[i] = comparatorSync[1];
                TCC_SRC_IOC:  sourceRaw[i] = changeEvent[i];
                default:      sourceRaw[i] = logicCellOut[selOf[i][1:0]];
            endcase
        end
    end

    always_comb
    begin
        triggerClear           = 3'b000;
        next_channelIrqFlag    = channelIrqFlag;
        next_compareEvent      = 2'b00;
        next_conversionTrigger = 2'b00;
        for (int i = 0; i < TCC_CHANNELS; i++)
        begin
            channelBase[i]  = (timerOf[i] < 2'h3) ? count[timerOf[i]] : count[0];
            next_ccValue[i] = ccValue[i];
            matchNow[i]     = (ccValue[i] == channelBase[i]);
            if (ccWriteLow[i])
                next_ccValue[i][7:0] = ccWriteData;
            if (ccWriteHigh[i])
                next_ccValue[i][15:8] = ccWriteData;
            // one event per match entry, not per cycle held
            if (matchNow[i] && !matchLast[i]
                && (modeOf[i] == TCC_MODE_CMP_EVT || modeOf[i] == TCC_MODE_CMP_TRIG))
            begin
                next_compareEvent[i]   = 1'b1;
                next_channelIrqFlag[i] = 1'b1;
                if (modeOf[i] == TCC_MODE_CMP_TRIG)
                begin
                    next_conversionTrigger[i] = 1'b1;
                    if (timerOf[i] < 2'h3)
                        triggerClear[timerOf[i]] = 1'b1;
                end
            end
            if (captureEvent[i])
            begin
                next_ccValue[i]        = channelBase[i];
                next_channelIrqFlag[i] = 1'b1;
            end
            // a capture or a real compare hit outranks the clear, not a match in capture mode
            else if (channelFlagClear[i] && !next_compareEvent[i])
                next_channelIrqFlag[i] = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ccValue[0]        <= TCC_CCVAL_RST;
            ccValue[1]        <= TCC_CCVAL_RST;
            channelIrqFlag    <= 2'b00;
            compareEvent      <= 2'b00;
            conversionTrigger <= 2'b00;
            matchLast         <= 2'b00;
        end
        else
        begin
            ccValue[0]        <= next_ccValue[0];
            ccValue[1]        <= next_ccValue[1];
            channelIrqFlag    <= next_channelIrqFlag;
            compareEvent      <= next_compareEvent;
            conversionTrigger <= next_conversionTrigger;
            matchLast         <= matchNow;
        end
    end

    assign ccValue0 = ccValue[0];
    assign ccValue1 = ccValue[1];

    // wake does not need the global enable; the isr does
    assign overflowIrq            = overflowFlag & timerRun & overflowIrqEnable;
    assign interruptRequest       = (|overflowIrq) & peripheralIrqEnable & globalIrqEnable;
    assign wakeRequest            = sleepMode & (|overflowIrq) & peripheralIrqEnable;
    assign vectorToIsr            = wakeRequest & globalIrqEnable;
    assign secondaryOscillatorRun = secondaryOscillatorEnable;

    irqNeedsAll_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        interruptRequest |-> (peripheralIrqEnable && globalIrqEnable && |(timerRun & overflowIrqEnable)))
        else $error("irq without all enables");
    captureCopies_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (captureEvent[0] && channelTimer0 == 2'h2) |=> (ccValue0 == $past(timerCount2)))
        else $error("capture did not copy count");
    captureSetsFlag_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        captureEvent[1] |=> channelIrqFlag[1])
        else $error("capture did not set channel flag");
    sleepHoldsCount_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (sleepMode && !freeRunSelect[1] && !timerWriteLow[1] && !timerWriteHigh[1] && !triggerClear[1])
        |=> (timerCount1 == $past(timerCount1)))
        else $error("sync timer counted in sleep");
    triggerClears_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (triggerClear[1] && !timerWriteLow[1] && !timerWriteHigh[1])
        |=> (timerCount1 == TCC_COUNT_ZERO))
        else $error("trigger did not clear timer");
    wakeGlobal_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wakeRequest && !globalIrqEnable) |-> !vectorToIsr)
        else $error("isr entered without global enable");
endmodule : tcc_top

// ### tb/tcc_partner.sv
// capture source drivers and conversion trigger consumer
// the bench calls setSource just after a rising edge
`timescale 1ns/1ns
module tcc_partner
    import tcc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic [1:0] conversionTrigger,
    output logic      [1:0] pinIn,
    output logic      [1:0] comparatorSync,
    output logic      [1:0] changeEvent,
    output logic      [3:0] logicCellOut,
    output int              triggerCount
);
    initial
    begin
        {pinIn, comparatorSync, changeEvent, logicCellOut} = 10'h000;
        triggerCount = 0;
    end
    // a missed trigger shows as a short count
    always @(posedge sys_clk)
        triggerCount <= triggerCount + int'(conversionTrigger[0]) + int'(conversionTrigger[1]);
    task automatic setSource(input int ch, input logic [2:0] sel, input logic level);
        case (sel)
            TCC_SRC_PIN:  pinIn[ch] = level;
            TCC_SRC_CMP1: comparatorSync[0] = level;
            TCC_SRC_CMP2: comparatorSync[1] = level;
            TCC_SRC_IOC:  changeEvent[ch] = level;
            default:      logicCellOut[sel[1:0]] = level;
        endcase
    endtask : setSource
endmodule : tcc_partner

// ### tb/test_timer_capture_compare_base.sv
// self-checking bench for the timer capture/compare base
// inputs move 1 ns after each rising edge; sources come from the partner
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("ERROR %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module test_timer_capture_compare_base
    import tcc_pkg::*;
;
    logic        sys_clk, reset_n, peripheralIrqEnable, globalIrqEnable, sleepMode, secondaryOscillatorEnable;
    logic [2:0]  timerRun, freeRunSelect, syncTick, asyncTick, timerWriteLow, timerWriteHigh;
    logic [2:0]  overflowFlagClear, overflowIrqEnable, sourceSelect0, sourceSelect1, overflowFlag;
    logic [3:0]  channelMode0, channelMode1, logicCellOut;
    logic [1:0]  channelTimer0, channelTimer1, pinIn, pinIsOutput, portLatch, comparatorSync, changeEvent;
    logic [1:0]  ccWriteLow, ccWriteHigh, channelFlagClear, channelIrqFlag, compareEvent, conversionTrigger;
    logic [7:0]  timerWriteData, ccWriteData;
    logic [15:0] timerCount0, timerCount1, timerCount2, ccValue0, ccValue1;
    logic        interruptRequest, wakeRequest, vectorToIsr, secondaryOscillatorRun;
    int          failures = 0;
    int          n_checks = 0;
    int          triggerCount;

    tcc_top DUT (.sys_clk, .reset_n, .timerRun, .freeRunSelect, .syncTick, .asyncTick, .timerWriteLow,
        .timerWriteHigh, .timerWriteData, .overflowFlagClear, .overflowIrqEnable, .peripheralIrqEnable,
        .globalIrqEnable, .sleepMode, .secondaryOscillatorEnable, .channelMode0, .channelMode1, .channelTimer0,
        .channelTimer1, .sourceSelect0, .sourceSelect1, .pinIn, .pinIsOutput, .portLatch, .comparatorSync,
        .changeEvent, .logicCellOut, .ccWriteLow, .ccWriteHigh, .ccWriteData, .channelFlagClear, .timerCount0,
        .timerCount1, .timerCount2, .overflowFlag, .ccValue0, .ccValue1, .channelIrqFlag, .compareEvent,
        .conversionTrigger, .interruptRequest, .wakeRequest, .vectorToIsr, .secondaryOscillatorRun);
    tcc_partner partner (.sys_clk, .conversionTrigger, .pinIn, .comparatorSync, .changeEvent, .logicCellOut,
        .triggerCount);

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    // low byte first; the high write lands one edge later
    task automatic writeWord(input bit cc, input logic [2:0] m, input logic [15:0] val);
        timerWriteData = val[7:0];
        ccWriteData = val[7:0];
        timerWriteLow = cc ? 3'h0 : m;
        ccWriteLow = cc ? m[1:0] : 2'h0;
        step(1);
        {timerWriteLow, ccWriteLow} = 5'h00;
        timerWriteData = val[15:8];
        ccWriteData = val[15:8];
        timerWriteHigh = cc ? 3'h0 : m;
        ccWriteHigh = cc ? m[1:0] : 2'h0;
        step(1);
        {timerWriteHigh, ccWriteHigh} = 5'h00;
    endtask : writeWord

    task automatic clearFlags(input logic [2:0] of, input logic [1:0] cf);
        overflowFlagClear = of;
        channelFlagClear = cf;
        step(1);
        {overflowFlagClear, channelFlagClear} = 5'h00;
    endtask : clearFlags

    // edges spaced three cycles apart, wider than the one-cycle minimum
    task automatic srcPulse(input int ch, input logic [2:0] sel);
        partner.setSource(ch, sel, 1'b1);
        step(3);
        partner.setSource(ch, sel, 1'b0);
        step(3);
    endtask : srcPulse

    task automatic testOverflow;
        writeWord(0, 3'h1, 16'hfffe);
        clearFlags(3'h1, 2'h0);
        {timerRun, syncTick} = 6'o11;
        step(1);
        `CHK(timerCount0, TCC_COUNT_MAX)
        `CHK(overflowFlag[0], 1'b0)
        step(1);
        syncTick = 3'h0;
        `CHK(timerCount0, TCC_COUNT_ZERO)
        `CHK(overflowFlag[0], 1'b1)
        step(5);
        `CHK(overflowFlag[0], 1'b1)
        for (int m = 0; m < 16; m++)
        begin
            {timerRun[0], overflowIrqEnable[0], peripheralIrqEnable, globalIrqEnable} = 4'(m);
            step(1);
            `CHK(interruptRequest, m == 15)
        end
        clearFlags(3'h1, 2'h0);
        `CHK(overflowFlag[0], 1'b0)
        {timerRun, overflowIrqEnable, peripheralIrqEnable, globalIrqEnable} = 8'h00;
        $display("overflow test done");
    endtask : testOverflow

    task automatic testSleep;
        for (int s = 0; s < 8; s++)
        begin
            {secondaryOscillatorEnable, sleepMode, freeRunSelect[1]} = 3'(s);
            step(1);
            `CHK(secondaryOscillatorRun, s[2])
        end
        writeWord(0, 3'h2, 16'hffff);
        {freeRunSelect[1], timerRun[1], syncTick[1]} = 3'b011;
        step(1);
        syncTick = 3'h0;
        `CHK(timerCount1, 16'hffff)
        {freeRunSelect[1], overflowIrqEnable[1], peripheralIrqEnable, asyncTick[1]} = 4'hf;
        step(1);
        asyncTick = 3'h0;
        `CHK(timerCount1, TCC_COUNT_ZERO)
        `CHK(wakeRequest, 1'b1)
        `CHK(vectorToIsr, 1'b0)
        globalIrqEnable = 1'b1;
        step(1);
        `CHK(vectorToIsr, 1'b1)
        {sleepMode, freeRunSelect, timerRun, overflowIrqEnable, peripheralIrqEnable, globalIrqEnable} = '0;
        clearFlags(3'h2, 2'h0);
        $display("sleep test done");
    endtask : testSleep

    task automatic testCapture;
        logic [3:0] modes [4] = '{TCC_MODE_FALL, TCC_MODE_RISE, TCC_MODE_RISE4, TCC_MODE_RISE16};
        int         need  [4] = '{1, 1, 4, 16};
        {channelTimer0, sourceSelect0} = {2'h2, TCC_SRC_PIN};
        pinIsOutput = 2'h0;
        for (int i = 0; i < 4; i++)
        begin
            channelMode0 = modes[i];
            writeWord(0, 3'h4, 16'h0a00 + 16'(i));
            clearFlags(3'h0, 2'h1);
            repeat (need[i] - 1) srcPulse(0, TCC_SRC_PIN);
            `CHK(channelIrqFlag[0], 1'b0)
            writeWord(0, 3'h4, 16'hc300 + 16'(i));
            `CHK(timerCount2, 16'hc300 + 16'(i))
            partner.setSource(0, TCC_SRC_PIN, 1'b1);
            step(5);
            `CHK(channelIrqFlag[0], 1'(modes[i] != TCC_MODE_FALL))
            partner.setSource(0, TCC_SRC_PIN, 1'b0);
            step(5);
            `CHK(ccValue0, 16'hc300 + 16'(i))
            `CHK(channelIrqFlag[0], 1'b1)
        end
        channelMode0 = TCC_MODE_RISE4;
        clearFlags(3'h0, 2'h1);
        repeat (2) srcPulse(0, TCC_SRC_PIN);
        channelMode0 = TCC_MODE_RISE16;
        step(2);
        channelMode0 = TCC_MODE_RISE4;
        repeat (3) srcPulse(0, TCC_SRC_PIN);
        `CHK(channelIrqFlag[0], 1'b0)
        srcPulse(0, TCC_SRC_PIN);
        `CHK(channelIrqFlag[0], 1'b1)
        channelMode0 = TCC_MODE_OFF;
        $display("capture test done");
    endtask : testCapture

    task automatic testSources;
        {channelMode1, channelTimer1} = {TCC_MODE_RISE, 2'h0};
        for (int s = 0; s < 8; s++)
        begin
            sourceSelect1 = 3'(s);
            clearFlags(3'h0, 2'h2);
            `CHK(channelIrqFlag[1], 1'b0)
            srcPulse(1, 3'(s));
            `CHK(channelIrqFlag[1], 1'b1)
        end
        {sourceSelect1, pinIsOutput} = {TCC_SRC_PIN, 2'h2};
        clearFlags(3'h0, 2'h2);
        portLatch = 2'h2;
        step(5);
        `CHK(channelIrqFlag[1], 1'b1)
        {portLatch, pinIsOutput} = 4'h0;
        $display("source test done");
    endtask : testSources

    task automatic testCompare;
        int n;
        channelTimer1 = 2'h1;
        writeWord(1, 3'h2, 16'h0010);
        writeWord(0, 3'h2, 16'h0000);
        clearFlags(3'h2, 2'h2);
        `CHK(ccValue1, 16'h0010)
        channelMode1 = TCC_MODE_CMP_TRIG;
        {timerRun[1], syncTick[1]} = 2'b11;
        n = 0;
        while (conversionTrigger[1] !== 1'b1 && n < 40)
        begin
            step(1);
            n++;
        end
        if (n == 40)
        begin
            failures++;
            report_and_stop();
        end
        `CHK(compareEvent[1], 1'b1)
        `CHK(timerCount1, TCC_COUNT_ZERO)
        `CHK(overflowFlag[1], 1'b0)
        `CHK(channelIrqFlag[1], 1'b1)
        step(17);
        `CHK(conversionTrigger[1], 1'b1)
        // partner counts a pulse one edge after it appears
        `CHK(triggerCount, 1)
        {timerRun[1], syncTick[1]} = 2'b00;
        writeWord(0, 3'h2, 16'h0010);
        `CHK(timerCount1, 16'h0010)
        `CHK(triggerCount, 2)
        step(3);
        `CHK(triggerCount, 3)
        channelMode1 = TCC_MODE_CMP_EVT;
        writeWord(0, 3'h2, 16'h000f);
        {timerRun[1], syncTick[1]} = 2'b11;
        step(1);
        {timerRun[1], syncTick[1]} = 2'b00;
        step(1);
        `CHK(compareEvent[1], 1'b1)
        `CHK(timerCount1, 16'h0010)
        `CHK(conversionTrigger[1], 1'b0)
        `CHK(triggerCount, 3)
        $display("compare test done");
    endtask : testCompare

    initial
    begin
        {timerRun, freeRunSelect, syncTick, asyncTick, timerWriteLow, timerWriteHigh, overflowFlagClear} = '0;
        {overflowIrqEnable, peripheralIrqEnable, globalIrqEnable, sleepMode, secondaryOscillatorEnable} = '0;
        {channelMode0, channelMode1, channelTimer0, channelTimer1, sourceSelect0, sourceSelect1} = '0;
        {pinIsOutput, portLatch, ccWriteLow, ccWriteHigh, ccWriteData, timerWriteData, channelFlagClear} = '0;
        reset_n = 1'b0;
        repeat (20) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        step(1);
        testOverflow();
        testSleep();
        testCapture();
        testSources();
        testCompare();
        report_and_stop();
    end
endmodule : test_timer_capture_compare_base
